// File: shared/asc_pkg.sv
// Shared types and constants for the converter scan-control block
package asc_pkg;

  localparam int CODE_W = 10;
  localparam int NUM_CH = 8;
  localparam int NEG_SEL_W = 3;
  localparam int BYPASS_CH = 4;
  localparam int CNT_W = 4;
  localparam int PROD_W = 2 * CODE_W;
  localparam int ARITH_W = 16;

  localparam logic [CODE_W-1:0] DAC_MIDPOINT = 10'h200;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic signed [ARITH_W-1:0] GAIN_UNITY_K = 16'sh0001;
  localparam logic signed [ARITH_W-1:0] GAIN_TEN_K = 16'sh000A;
  localparam logic signed [ARITH_W-1:0] GAIN_TWENTY_K = 16'sh0014;
  localparam logic [CNT_W-1:0] ASSIST_PERIODS = 4'h2;
  localparam logic [CNT_W-1:0] UNASSISTED_PERIODS = 4'h6;

  typedef struct packed {
    logic comparator_precharge_n;
    logic settle_assist;
    logic gain_stage_power_on;
    logic bypass_connect;
    logic neg_input_ground_sel;
    logic internal_ref_to_dac;
    logic supply_ref_sel;
    logic [NEG_SEL_W-1:0] neg_mux_sel;
    logic passgate_enable;
    logic switchcap_test_out;
    logic gain_ten_enable;
    logic gain_twenty_enable;
    logic hold_ctrl;
    logic gain_clk;
    logic [NUM_CH-1:0] input_select;
    logic [CODE_W-1:0] dac_code;
  } asc_ctrl_t;

  localparam asc_ctrl_t CTRL_IDLE = '{
    comparator_precharge_n: 1'b1,
    bypass_connect: 1'b1,
    passgate_enable: 1'b1,
    hold_ctrl: 1'b1,
    input_select: 8'h01,
    default: '0
  };

  typedef struct packed {
    logic [CODE_W-1:0] bandgap;
    logic [CODE_W-1:0] external_ref;
    logic [CODE_W-1:0] supply;
  } asc_refs_t;

  typedef enum logic [1:0] {
    REF_EXTERNAL = 2'b00,
    REF_BANDGAP = 2'b01,
    REF_SUPPLY = 2'b11
  } asc_ref_src_t;

  typedef enum logic [1:0] {
    GS_OFF = 2'b00,
    GS_SETTLING = 2'b01,
    GS_READY = 2'b11
  } asc_gain_st_t;

  typedef struct packed {
    logic bypass_active;
    logic neg_grounded;
    logic passgate_closed;
    logic gain_ready;
    logic select_fault;
    logic hold_timing_fault;
    logic dac_unstable_fault;
  } asc_status_t;

  typedef struct packed {
    asc_ctrl_t ctrl;
    logic [CODE_W-1:0] held;
    logic latch;
    logic comparator_precharge_n_q;
    logic aclk_q;
    logic hold_q;
    logic power_q;
    asc_gain_st_t gs;
    logic [CNT_W-1:0] settle_cnt;
    logic assist_ok;
    logic [CODE_W-1:0] gain_code;
    logic [CODE_W-1:0] test_code;
    logic test_oe;
    logic [CODE_W-1:0] test_pin;
    logic [CODE_W-1:0] neg_code;
    logic [CODE_W-1:0] ref_code;
    asc_ref_src_t ref_src;
    asc_status_t status;
  } asc_state_t;

  localparam asc_state_t STATE_RESET = '{
    ctrl: CTRL_IDLE,
    comparator_precharge_n_q: 1'b1,
    hold_q: 1'b1,
    gs: GS_OFF,
    ref_src: REF_EXTERNAL,
    status: '{bypass_active: 1'b1, passgate_closed: 1'b1, default: '0},
    default: '0
  };

endpackage

// File: design/asc_core.sv
// Digital model of the converter analog core behind its scan-driven controls
`timescale 1ns/1ps
module asc_core #(
  parameter logic [asc_pkg::CNT_W-1:0] UNASSIST_PERIODS = asc_pkg::UNASSISTED_PERIODS
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire asc_pkg::asc_ctrl_t CTRL_I,
  input wire logic [asc_pkg::NUM_CH-1:0][asc_pkg::CODE_W-1:0] ANALOG_CH_I,
  input wire asc_pkg::asc_refs_t REFS_I,
  output asc_pkg::asc_ctrl_t CTRL_ECHO_O,
  output logic COMP_O,
  output logic [asc_pkg::CODE_W-1:0] HELD_CODE_O,
  output logic [asc_pkg::CODE_W-1:0] NEG_CODE_O,
  output logic [asc_pkg::CODE_W-1:0] REF_CODE_O,
  output asc_pkg::asc_ref_src_t REF_SRC_O,
  output logic [asc_pkg::CODE_W-1:0] GAIN_CODE_O,
  output logic [asc_pkg::CODE_W-1:0] TEST_PIN_O,
  output logic TEST_PIN_OE_O,
  output asc_pkg::asc_status_t STATUS_O
);
  import asc_pkg::*;

  asc_state_t st_r;
  asc_state_t st_nxt;

  function automatic logic [CODE_W-1:0] sat_code(input logic signed [ARITH_W-1:0] v);
    logic [CODE_W-1:0] r;
    if (v < 0) begin
      r = '0;
    end else if (v > $signed({6'h00, CODE_MAX})) begin
      r = CODE_MAX;
    end else begin
      r = v[CODE_W-1:0];
    end
    return r;
  endfunction

  logic [CODE_W-1:0] gain_in;
  logic [CODE_W-1:0] pos_sample;
  logic [CODE_W-1:0] neg_val;
  logic [CODE_W-1:0] ref_val;
  logic [CODE_W-1:0] dac_level;
  logic [PROD_W-1:0] dac_prod;
  logic signed [ARITH_W-1:0] diff;
  logic signed [ARITH_W-1:0] gain_k;
  logic signed [ARITH_W-1:0] diff_sel;
  logic signed [ARITH_W-1:0] diff_ten;
  logic signed [ARITH_W-1:0] comp_lhs;
  logic aclk_rise;
  logic comparator_precharge_n_rise;
  logic hold_rise;
  logic power_rise;
  logic gain_path;
  logic decision;
  logic [CNT_W-1:0] need;

  always_comb begin
    st_nxt = st_r;
    gain_in = '0;
    pos_sample = '0;
    aclk_rise = CTRL_I.gain_clk & ~st_r.aclk_q;
    comparator_precharge_n_rise = CTRL_I.comparator_precharge_n & ~st_r.comparator_precharge_n_q;
    hold_rise = CTRL_I.hold_ctrl & ~st_r.hold_q;
    power_rise = CTRL_I.gain_stage_power_on & ~st_r.power_q;

    // Observed copy of every control, so idle inputs read back as idle
    st_nxt.ctrl = CTRL_I;
    st_nxt.aclk_q = CTRL_I.gain_clk;
    st_nxt.comparator_precharge_n_q = CTRL_I.comparator_precharge_n;
    st_nxt.hold_q = CTRL_I.hold_ctrl;
    st_nxt.power_q = CTRL_I.gain_stage_power_on;

    // Negative input: ground wins over the channel field
    if (CTRL_I.neg_input_ground_sel) begin
      neg_val = '0;
    end else begin
      neg_val = ANALOG_CH_I[CTRL_I.neg_mux_sel];
    end
    st_nxt.neg_code = neg_val;

    // Reference source; supply takes priority over the bandgap
    if (CTRL_I.supply_ref_sel) begin
      ref_val = REFS_I.supply;
      st_nxt.ref_src = REF_SUPPLY;
    end else if (CTRL_I.internal_ref_to_dac) begin
      ref_val = REFS_I.bandgap;
      st_nxt.ref_src = REF_BANDGAP;
    end else begin
      ref_val = REFS_I.external_ref;
      st_nxt.ref_src = REF_EXTERNAL;
    end
    st_nxt.ref_code = ref_val;

    // Gain stage input is the selected low channel
    for (int i = 0; i < BYPASS_CH; i++) begin
      if (CTRL_I.input_select[i]) begin
        gain_in = gain_in | ANALOG_CH_I[i];
      end
    end
    diff = $signed({6'h00, gain_in}) - $signed({6'h00, neg_val});
    if (CTRL_I.gain_twenty_enable) begin
      gain_k = GAIN_TWENTY_K;
    end else if (CTRL_I.gain_ten_enable) begin
      gain_k = GAIN_TEN_K;
    end else begin
      gain_k = GAIN_UNITY_K;
    end
    diff_sel = diff * gain_k;
    diff_ten = diff * GAIN_TEN_K;

    // Settling sequencer; assist is judged over the first periods only
    need = st_r.assist_ok ? ASSIST_PERIODS : UNASSIST_PERIODS;
    unique case (st_r.gs)
      GS_OFF: begin
        if (power_rise) begin
          st_nxt.gs = GS_SETTLING;
          // A gain clock that starts together with the power is its first period
          st_nxt.settle_cnt = aclk_rise ? 4'h1 : 4'h0;
          st_nxt.assist_ok = CTRL_I.settle_assist | ~aclk_rise;
        end
      end
      GS_SETTLING: begin
        if (!CTRL_I.gain_stage_power_on) begin
          st_nxt.gs = GS_OFF;
        end else if (aclk_rise) begin
          st_nxt.settle_cnt = st_r.settle_cnt + 4'h1;
          if (st_r.settle_cnt < ASSIST_PERIODS && !CTRL_I.settle_assist) begin
            st_nxt.assist_ok = 1'b0;
          end
          if (st_r.settle_cnt + 4'h1 >= need) begin
            st_nxt.gs = GS_READY;
          end
        end
      end
      GS_READY: begin
        if (!CTRL_I.gain_stage_power_on) begin
          st_nxt.gs = GS_OFF;
        end
      end
      default: begin
        st_nxt.gs = GS_OFF;
      end
    endcase

    // Switch-cap stages move on their own clock edge and clear to zero while unpowered
    if (!CTRL_I.gain_stage_power_on) begin
      st_nxt.gain_code = '0;
      st_nxt.test_code = '0;
    end else if (aclk_rise) begin
      st_nxt.gain_code = sat_code(diff_sel);
      st_nxt.test_code = sat_code(diff_ten);
    end

    // Test pin carries the x10 stage output while enabled
    st_nxt.test_oe = CTRL_I.switchcap_test_out;
    st_nxt.test_pin = st_nxt.test_oe ? st_nxt.test_code : '0;

    // Positive sample path; low channels need bypass or a closed gain path
    gain_path = (st_r.gs == GS_READY) & CTRL_I.passgate_enable;
    for (int i = 0; i < NUM_CH; i++) begin
      if (CTRL_I.input_select[i]) begin
        if (i >= BYPASS_CH) begin
          pos_sample = pos_sample | ANALOG_CH_I[i];
        end else if (CTRL_I.bypass_connect) begin
          pos_sample = pos_sample | ANALOG_CH_I[i];
        end else if (gain_path) begin
          pos_sample = pos_sample | st_r.gain_code;
        end
      end
    end

    // Sample while low, freeze while high
    if (!CTRL_I.hold_ctrl) begin
      st_nxt.held = pos_sample;
    end

    // Comparator against the scaled DAC level
    dac_prod = {10'h000, CTRL_I.dac_code} * {10'h000, ref_val};
    dac_level = dac_prod[PROD_W-1:CODE_W];
    comp_lhs = $signed({6'h00, st_r.held}) - $signed({6'h00, neg_val});
    decision = comp_lhs > $signed({6'h00, dac_level});

    // Latch decides once on release and keeps it until next precharge
    if (!CTRL_I.comparator_precharge_n) begin
      st_nxt.latch = 1'b0;
    end else if (comparator_precharge_n_rise) begin
      st_nxt.latch = decision;
    end

    st_nxt.status.bypass_active = CTRL_I.bypass_connect;
    st_nxt.status.neg_grounded = CTRL_I.neg_input_ground_sel;
    st_nxt.status.passgate_closed = CTRL_I.passgate_enable;
    st_nxt.status.gain_ready = (st_nxt.gs == GS_READY);
    // Fault flags are sticky until reset; they only report, never gate
    if (CTRL_I.input_select == '0 ||
        (CTRL_I.input_select & (CTRL_I.input_select - 8'h01)) != '0) begin
      st_nxt.status.select_fault = 1'b1;
    end
    if (hold_rise && CTRL_I.gain_stage_power_on && !CTRL_I.gain_clk) begin
      st_nxt.status.hold_timing_fault = 1'b1;
    end
    if (!CTRL_I.hold_ctrl && CTRL_I.dac_code != DAC_MIDPOINT) begin
      st_nxt.status.dac_unstable_fault = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign CTRL_ECHO_O = st_r.ctrl;
  assign COMP_O = st_r.latch;
  assign HELD_CODE_O = st_r.held;
  assign NEG_CODE_O = st_r.neg_code;
  assign REF_CODE_O = st_r.ref_code;
  assign REF_SRC_O = st_r.ref_src;
  assign GAIN_CODE_O = st_r.gain_code;
  assign TEST_PIN_O = st_r.test_pin;
  assign TEST_PIN_OE_O = st_r.test_oe;
  assign STATUS_O = st_r.status;

endmodule

// File: verif/asc_core_asserts.sv
// Port assertions for the converter scan-control core
`timescale 1ns/1ps
module asc_core_asserts (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire asc_pkg::asc_ctrl_t CTRL_I,
  input wire logic [asc_pkg::NUM_CH-1:0][asc_pkg::CODE_W-1:0] ANALOG_CH_I,
  input wire asc_pkg::asc_refs_t REFS_I,
  input wire asc_pkg::asc_ctrl_t CTRL_ECHO_O,
  input wire logic COMP_O,
  input wire logic [asc_pkg::CODE_W-1:0] HELD_CODE_O,
  input wire logic [asc_pkg::CODE_W-1:0] NEG_CODE_O,
  input wire logic [asc_pkg::CODE_W-1:0] REF_CODE_O,
  input wire asc_pkg::asc_ref_src_t REF_SRC_O,
  input wire logic [asc_pkg::CODE_W-1:0] TEST_PIN_O,
  input wire logic TEST_PIN_OE_O,
  input wire asc_pkg::asc_status_t STATUS_O
);
  import asc_pkg::*;
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  echo_delay_a: assert property (1 |=> CTRL_ECHO_O == $past(CTRL_I))
    else $error("echo not one cycle behind");
  hold_track_a: assert property (!CTRL_I.hold_ctrl && CTRL_I.bypass_connect &&
    CTRL_I.input_select == 8'h08 |=> HELD_CODE_O == $past(ANALOG_CH_I[3]))
    else $error("sample not tracking");
  hold_freeze_a: assert property (CTRL_I.hold_ctrl |=> $stable(HELD_CODE_O))
    else $error("held value moved");
  comparator_precharge_n_clear_a: assert property (!CTRL_I.comparator_precharge_n |=> !COMP_O)
    else $error("latch not precharged");
  comp_stand_a: assert property (CTRL_I.comparator_precharge_n &&
    CTRL_ECHO_O.comparator_precharge_n |=> $stable(COMP_O))
    else $error("latch moved while released");
  bypass_a: assert property (1 |=> STATUS_O.bypass_active == $past(CTRL_I.bypass_connect))
    else $error("bypass status wrong");
  ground_a: assert property (CTRL_I.neg_input_ground_sel |=> NEG_CODE_O == '0
    && STATUS_O.neg_grounded) else $error("negative input not grounded");
  iref_a: assert property (CTRL_I.internal_ref_to_dac && !CTRL_I.supply_ref_sel |=>
    REF_SRC_O == REF_BANDGAP && REF_CODE_O == $past(REFS_I.bandgap))
    else $error("bandgap not used");
  supply_a: assert property (CTRL_I.supply_ref_sel |=> REF_SRC_O == REF_SUPPLY
    && REF_CODE_O == $past(REFS_I.supply)) else $error("supply not used");
  pass_a: assert property (1 |=> STATUS_O.passgate_closed == $past(CTRL_I.passgate_enable))
    else $error("pass-gate status wrong");
  test_off_a: assert property (!CTRL_I.switchcap_test_out [*2] |=> !TEST_PIN_OE_O
    && TEST_PIN_O == '0) else $error("test pin driven");
  cover property (COMP_O);
  cover property (STATUS_O.gain_ready);
  cover property (TEST_PIN_OE_O);
endmodule
bind asc_core asc_core_asserts asc_core_asserts_inst (.*);

// File: verif/asc_scan_drv.sv
// Scan-register model that drives the core controls
`timescale 1ns/1ps
module asc_scan_drv (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire asc_pkg::asc_ctrl_t req_i,
  output asc_pkg::asc_ctrl_t ctrl_o
);
  import asc_pkg::*;
  logic [1:0] per_r;
  asc_ctrl_t c;
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_o <= CTRL_IDLE;
      per_r <= '0;
    end else begin
      c = req_i;
      // Gain clock stands still while the stages are unpowered
      c.gain_clk = c.gain_stage_power_on & ~ctrl_o.gain_clk;
      // Assist spans exactly two full gain-clock periods from power-on
      c.settle_assist = c.gain_stage_power_on &&
        (({1'b0, per_r} + {2'b00, c.gain_clk}) <= 3'd2);
      if (c.gain_clk && per_r < 2'd3) begin
        per_r <= per_r + 2'd1;
      end
      if (!c.gain_stage_power_on) begin
        per_r <= '0;
      end
      // Delay a hold rise by a cycle rather than break the gain timing
      if (c.gain_stage_power_on && c.hold_ctrl && !ctrl_o.hold_ctrl && !c.gain_clk) begin
        c.hold_ctrl = 1'b0;
      end
      if (!c.hold_ctrl) begin
        c.dac_code = DAC_MIDPOINT;
      end
      ctrl_o <= c;
    end
  end
endmodule

// File: verif/asc_core_bench.sv
// Self-checking bench for the converter scan-control core
`timescale 1ns/1ps
module asc_core_bench;
  import asc_pkg::*;
  logic CLK_I;
  logic RSTN_I;
  asc_ctrl_t req;
  asc_ctrl_t ctrl;
  asc_ctrl_t echo;
  logic [NUM_CH-1:0][CODE_W-1:0] ch;
  asc_refs_t refs;
  logic comp;
  logic oe;
  logic [CODE_W-1:0] held;
  logic [CODE_W-1:0] neg;
  logic [CODE_W-1:0] refc;
  logic [CODE_W-1:0] tpin;
  logic [CODE_W-1:0] gcode;
  asc_ref_src_t rsrc;
  asc_status_t st;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  asc_scan_drv asc_scan_drv_inst (.clk_i(CLK_I), .rstn_i(RSTN_I), .req_i(req), .ctrl_o(ctrl));
  // Long unassisted settle so only the assisted path meets the wait bound
  asc_core #(.UNASSIST_PERIODS(4'hF)) asc_core_inst (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .CTRL_I(ctrl), .ANALOG_CH_I(ch), .REFS_I(refs),
    .CTRL_ECHO_O(echo), .COMP_O(comp), .HELD_CODE_O(held), .NEG_CODE_O(neg),
    .REF_CODE_O(refc), .REF_SRC_O(rsrc), .GAIN_CODE_O(gcode), .TEST_PIN_O(tpin),
    .TEST_PIN_OE_O(oe), .STATUS_O(st));
  initial begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  task give_verdict;
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      give_verdict;
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task put(input asc_ctrl_t c);
    @(posedge CLK_I);
    req <= c;
  endtask
  // Two-cycle path: scan model register, then core register
  task step(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask
  task t_idle;
    put(CTRL_IDLE);
    step(2);
    chk(echo, CTRL_IDLE);
    chk(st.bypass_active, 1'b1);
    chk(st.passgate_closed, 1'b1);
    chk({oe, tpin}, '0);
  endtask
  task pulse(input asc_ctrl_t c, input logic [9:0] d, input logic e);
    c.dac_code = d;
    c.comparator_precharge_n = 1'b0;
    put(c);
    step(2);
    chk(comp, 1'b0);
    c.comparator_precharge_n = 1'b1;
    put(c);
    step(2);
    chk(comp, e);
    step(3);
    chk(comp, e);
  endtask
  task t_measure;
    asc_ctrl_t c;
    c = CTRL_IDLE;
    c.neg_input_ground_sel = 1'b1;
    c.input_select = 8'h08;
    c.hold_ctrl = 1'b0;
    put(c);
    ch[3] <= 10'h123;
    step(2);
    chk(held, 10'h123);
    chk({st.neg_grounded, neg}, {1'b1, 10'h000});
    c.hold_ctrl = 1'b1;
    put(c);
    step(2);
    @(posedge CLK_I) ch[3] <= 10'h0AA;
    step(2);
    chk(held, 10'h123);
    pulse(c, 10'h100, 1'b1);
    pulse(c, 10'h200, 1'b0);
    chk({st.dac_unstable_fault, st.select_fault}, 2'b00);
  endtask
  task t_refs;
    asc_ctrl_t c;
    c = CTRL_IDLE;
    c.internal_ref_to_dac = 1'b1;
    put(c);
    step(2);
    chk({rsrc, refc}, {REF_BANDGAP, refs.bandgap});
    c.supply_ref_sel = 1'b1;
    put(c);
    step(2);
    chk({rsrc, refc}, {REF_SUPPLY, refs.supply});
    put(CTRL_IDLE);
    step(2);
    chk({rsrc, refc}, {REF_EXTERNAL, refs.external_ref});
  endtask
  task t_misc;
    asc_ctrl_t c;
    c = CTRL_IDLE;
    c.switchcap_test_out = 1'b1;
    c.passgate_enable = 1'b0;
    c.bypass_connect = 1'b0;
    c.neg_mux_sel = 3'h5;
    put(c);
    ch[5] <= 10'h2C3;
    step(2);
    chk({oe, tpin}, {1'b1, 10'h000});
    chk(neg, 10'h2C3);
    chk({st.passgate_closed, st.bypass_active, st.neg_grounded}, 3'b000);
  endtask
  task t_gain;
    asc_ctrl_t c;
    c = CTRL_IDLE;
    c.gain_stage_power_on = 1'b1;
    c.gain_ten_enable = 1'b1;
    c.neg_input_ground_sel = 1'b1;
    c.switchcap_test_out = 1'b1;
    c.input_select = 8'h02;
    put(c);
    ch[1] <= 10'h010;
    for (int i = 0; i < 14 && st.gain_ready !== 1'b1; i++) step(1);
    chk(st.gain_ready, 1'b1);
    chk({oe, tpin}, {1'b1, 10'h0A0});
    chk(gcode, 10'h0A0);
    // Bypass off: a low channel reaches the hold only through the gain path
    c.bypass_connect = 1'b0;
    c.hold_ctrl = 1'b0;
    put(c);
    step(4);
    chk(held, 10'h0A0);
    c.hold_ctrl = 1'b1;
    put(c);
    step(4);
    c.passgate_enable = 1'b0;
    c.hold_ctrl = 1'b0;
    put(c);
    step(4);
    chk(held, 10'h000);
    c.hold_ctrl = 1'b1;
    put(c);
    step(4);
    chk(st.hold_timing_fault, 1'b0);
    chk(st.dac_unstable_fault, 1'b0);
    put(CTRL_IDLE);
    step(2);
  endtask
  initial begin
    RSTN_I = 1'b0;
    req = CTRL_IDLE;
    ch = '0;
    refs = '{bandgap: 10'h155, external_ref: 10'h3FF, supply: 10'h2AA};
    repeat (10) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    t_idle;
    t_measure;
    t_refs;
    t_misc;
    t_gain;
    give_verdict;
  end
endmodule
